//--- design/hkbs_params.svh
// constants of the keyboard scan core: opcodes, report layout, timing figures
// assumes inclusion by bare name from design and bench files
`ifndef HKBS_PARAMS_SVH
`define HKBS_PARAMS_SVH
`define HKBS_CLK_MHZ    125
`define HKBS_ROW_US     800
`define HKBS_PER_MS     25
`define HKBS_RST_US     600
`define HKBS_OP_RESET   4'h1
`define HKBS_OP_GET     4'h2
`define HKBS_OP_SET     4'h3
`define HKBS_OP_PWR     4'h8
`define HKBS_PWR_SLEEP  8'h01
`define HKBS_OUT_LEN    16'h0003
`define HKBS_DEF_LEN    8'h0B
`define HKBS_SPEC_LEN   8'h04
`define HKBS_NBYTES     4'hB
`define HKBS_LAST_EMPTY 4'h1
`define HKBS_LAST_DEF   4'hA
`define HKBS_LAST_SPEC  4'h3
`define HKBS_MOD_PFX    5'h1C
`define HKBS_NKEYS      3'h6
`define HKBS_NPOS       8'h80
`define HKBS_LAST_ROW   4'hF
`define HKBS_ROW0       16'h0001
`define HKBS_SETTLE     2'h3
`endif

//--- design/hkbs_pkg.sv
// types used only by the keyboard scan core, not by its map memory
// assumes nothing of its surroundings
package hkbs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SCAN = 3'h1,
    ST_MAPF = 3'h3,
    ST_MAPK = 3'h2,
    ST_HOLD = 3'h6
  } hkbs_st_t;
  typedef enum logic [1:0] {K_EMPTY, K_DEF, K_SPEC} hkbs_kind_t;
  typedef enum logic [1:0] {CL_IGN, CL_MOD, CL_SPEC, CL_KEY} hkbs_cls_t;
endpackage

//--- design/hkbs_map_if.sv
// link between the scan core and its keyboard map memory
// assumes both ends run on the core clock
`timescale 1ns/1ns
interface hkbs_map_if;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] rd_addr;
  logic [7:0] pri;
  logic [7:0] alt;
  modport core (output wr_en, wr_addr, wr_data, rd_addr, input pri, alt);
  modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output pri, alt);
endinterface

//--- design/hkbs_keymap_mem.sv
// primary and alternate keyboard map, one byte per matrix position
// assumes writes and reads on the core clock; contents are not reset
`timescale 1ns/1ns
module hkbs_keymap_mem #(
  parameter int AW = 7
) (
  input wire logic clk,  // core clock
  hkbs_map_if.mem  map   // map access
);
  logic [7:0] pri_mem [0:(1<<AW)-1];
  logic [7:0] alt_mem [0:(1<<AW)-1];
  logic [7:0] pri_ff;
  logic [7:0] alt_ff;

  // address bit AW selects the alternate half on writes
  always_ff @(posedge clk) begin
    if (map.wr_en && !map.wr_addr[AW]) begin
      pri_mem[map.wr_addr[AW-1:0]] <= map.wr_data;
    end
    if (map.wr_en && map.wr_addr[AW]) begin
      alt_mem[map.wr_addr[AW-1:0]] <= map.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    pri_ff <= pri_mem[map.rd_addr];
    alt_ff <= alt_mem[map.rd_addr];
  end

  assign map.pri = pri_ff;
  assign map.alt = alt_ff;
endmodule

//--- design/hkbs_core.sv
// keyboard matrix scanner producing input reports, indicators and interrupt
// assumes a host-side byte engine on link_clk; map written on clk before use
// Notes on behaviour
// - report reads through the data register never clear a pending interrupt
// - sleep turns indicators off and empties the input report
// - sleep stops scanning; presses ignored until all keys released
// - wake with a key held restarts scanning and raises interrupt
// - wake restores indicators to the latest stored state
// - after release following sleep, new presses report and interrupt
// - each position has primary and alternate code; function modifier selects alternate
// - zero codes are ignored, the function modifier included
// - idle keeps rows low; any low column starts a scan
// - scan enables oscillator and drives each row low per step
// - full scan repeats each period while keys stay pressed
// - release yields a report of remaining keys or zero codes
// - a new report asserts the active-low interrupt
// - interrupt clears on input reads at the report's last byte
// - clear takes effect at the acknowledge after the last byte
// - report keeps being overwritten while interrupt stays asserted
// - after reset the length field is zero and interrupt asserted
// - power-on reset holds the core and restores all defaults
// - reset command resets fully for a while, ignoring host traffic
// - opcodes decode as reset, set report, set power; get report has no decode
// - low four bits of output report drive indicators, one is on
`timescale 1ns/1ns
`include "hkbs_params.svh"
module hkbs_core
  import hkbs_pkg::*;
#(
  parameter int         ROW_CYC = `HKBS_ROW_US * `HKBS_CLK_MHZ,
  parameter int         PER_CYC = `HKBS_PER_MS * 1000 * `HKBS_CLK_MHZ,
  parameter int         RST_CYC = `HKBS_RST_US * `HKBS_CLK_MHZ,
  parameter logic [7:0] FN_CODE = 8'hF0,
  parameter logic [7:0] DEF_ID  = 8'h01,
  parameter logic [7:0] SPEC_ID = 8'h02,
  parameter logic [7:0] SPEC_LO = 8'hC0
) (
  input  wire logic        clk,                 // core clock
  input  wire logic        rst,                 // power-on reset
  input  wire logic        link_clk,            // host link clock
  input  wire logic [7:0]  column_sense_inputs, // matrix columns, low = key
  output logic      [15:0] row_drive_outputs,   // matrix rows, low = driven
  output logic      [3:0]  indicator_outputs,   // indicators, one = lit
  output logic             int_n,               // interrupt, active low
  output logic             osc_en,              // oscillator enable
  input  wire logic        map_wr_en,           // map write strobe
  input  wire logic [7:0]  map_wr_addr,         // map write address
  input  wire logic [7:0]  map_wr_data,         // map write byte
  input  wire logic        lk_cmd_stb,          // command pulse
  input  wire logic [3:0]  lk_cmd_op,           // command opcode
  input  wire logic [15:0] lk_cmd_len,          // payload length field
  input  wire logic [7:0]  lk_cmd_arg,          // payload byte
  input  wire logic [3:0]  lk_rd_idx,           // report byte index
  output logic      [7:0]  lk_rd_data,          // report byte
  input  wire logic        lk_ack_stb,          // ack/nack bit of a read byte
  input  wire logic [3:0]  lk_ack_idx,          // index of that byte
  input  wire logic        lk_ack_input         // read is of input register
);
  localparam int SCW = $clog2(ROW_CYC + 1);
  localparam int PCW = $clog2(PER_CYC + 1);
  localparam int RCW = $clog2(RST_CYC + 1);

  function automatic hkbs_cls_t key_class(input logic [7:0] c);
    if (c == 8'h00 || c == FN_CODE) key_class = CL_IGN;
    else if (c[7:3] == `HKBS_MOD_PFX) key_class = CL_MOD;
    else if (c[7:3] == SPEC_LO[7:3]) key_class = CL_SPEC;
    else key_class = CL_KEY;
  endfunction

  hkbs_map_if map_if ();
  hkbs_keymap_mem u_mem (.clk(clk), .map(map_if));

  logic [7:0]     col_s1_ff, col_ff;
  logic           srst_ff;
  logic [RCW-1:0] srst_cnt_ff;
  logic           cmd_s1_ff, cmd_s2_ff, cmd_d_ff, clr_s1_ff, clr_s2_ff, clr_d_ff;
  logic           lk_cmd_tgl_ff, lk_clr_tgl_ff;
  logic [3:0]     lk_op_ff;
  logic [15:0]    lk_len_ff;
  logic [7:0]     lk_arg_ff;
  logic [3:0]     led_state_ff, led_out_ff;
  logic           sleeping_ff, lock_ff, fn_ff, int_ff, int_n_ff, osc_ff;
  logic [1:0]     settle_ff;
  hkbs_st_t       st_ff;
  logic [3:0]     row_ff;
  logic [15:0]    row_out_ff;
  logic [SCW-1:0] step_ff;
  logic [PCW-1:0] per_ff;
  logic [7:0]     idx_ff;
  logic [127:0]   mat_ff;
  logic [7:0]     mod_acc_ff, spec_acc_ff;
  logic [47:0]    keys_acc_ff;
  logic [2:0]     nk_ff;
  logic [87:0]    rpt_ff, sh_rpt_ff, nxt_rpt;
  hkbs_kind_t     kind_ff, sh_kind_ff, nxt_kind;
  logic           pub_tgl_ff;
  logic           rpt_done_ff;

  wire core_rst = rst | srst_ff;
  wire any_low  = ~&col_ff;
  wire cmd_ev   = cmd_s2_ff ^ cmd_d_ff;
  wire clr_ev   = clr_s2_ff ^ clr_d_ff;
  wire cmd_ok   = cmd_ev && !srst_ff;
  wire go_reset = cmd_ok && lk_op_ff == `HKBS_OP_RESET;
  wire go_set   = cmd_ok && lk_op_ff == `HKBS_OP_SET
                  && lk_len_ff == `HKBS_OUT_LEN;
  wire go_pwr   = cmd_ok && lk_op_ff == `HKBS_OP_PWR;
  wire go_sleep = go_pwr && lk_arg_ff == `HKBS_PWR_SLEEP;
  wire go_wake  = go_pwr && lk_arg_ff != `HKBS_PWR_SLEEP;
  wire per_done = per_ff >= PCW'(PER_CYC - 1);
  wire start    = (st_ff == ST_IDLE && any_low && !lock_ff)
                  || (st_ff == ST_HOLD && per_done);
  wire in_map   = st_ff == ST_MAPF || st_ff == ST_MAPK;
  wire proc     = in_map && idx_ff != 8'h00;
  wire [6:0] pos = 7'(idx_ff - 8'h01);
  wire pressed  = mat_ff[pos];
  wire [7:0] code = fn_ff ? map_if.alt : map_if.pri;
  wire rpt_done = rpt_done_ff;
  wire new_rpt  = rpt_done && (nxt_rpt != rpt_ff || nxt_kind != kind_ff);

  assign map_if.wr_en   = map_wr_en;
  assign map_if.wr_addr = map_wr_addr;
  assign map_if.wr_data = map_wr_data;
  assign map_if.rd_addr = idx_ff[6:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      col_s1_ff <= 8'hFF;
      col_ff    <= 8'hFF;
    end else begin
      col_s1_ff <= column_sense_inputs;
      col_ff    <= col_s1_ff;
    end
  end

  // crossing flops see only the power-on reset, so a soft reset fakes no event
  always_ff @(posedge clk) begin
    if (rst) begin
      {cmd_s1_ff, cmd_s2_ff, cmd_d_ff} <= 3'h0;
      {clr_s1_ff, clr_s2_ff, clr_d_ff} <= 3'h0;
    end else begin
      {cmd_s1_ff, cmd_s2_ff, cmd_d_ff} <= {lk_cmd_tgl_ff, cmd_s1_ff, cmd_s2_ff};
      {clr_s1_ff, clr_s2_ff, clr_d_ff} <= {lk_clr_tgl_ff, clr_s1_ff, clr_s2_ff};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      srst_ff     <= 1'b0;
      srst_cnt_ff <= '0;
    end else if (go_reset) begin
      srst_ff     <= 1'b1;
      srst_cnt_ff <= '0;
    end else if (srst_ff) begin
      if (srst_cnt_ff == RCW'(RST_CYC - 1)) srst_ff <= 1'b0;
      srst_cnt_ff <= srst_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      led_state_ff <= '0;
      led_out_ff   <= '0;
      sleeping_ff  <= 1'b0;
    end else begin
      if (go_set) led_state_ff <= lk_arg_ff[3:0];
      if (go_sleep) sleeping_ff <= 1'b1;
      else if (go_wake) sleeping_ff <= 1'b0;
      led_out_ff <= sleeping_ff ? 4'h0 : led_state_ff;
    end
  end

  // lock lifts on wake, or once rows have sat low long enough for columns to settle and all columns read high
  always_ff @(posedge clk) begin
    if (core_rst) begin
      lock_ff   <= 1'b0;
      settle_ff <= '0;
    end else begin
      if (st_ff != ST_IDLE || row_out_ff != 16'h0000) settle_ff <= '0;
      else if (settle_ff != `HKBS_SETTLE) settle_ff <= settle_ff + 1'b1;
      if (go_sleep) lock_ff <= 1'b1;
      else if (go_wake || (settle_ff == `HKBS_SETTLE && !any_low)) begin
        lock_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst || go_sleep) begin
      st_ff   <= ST_IDLE;
      row_ff  <= '0;
      step_ff <= '0;
      idx_ff  <= '0;
    end else begin
      unique case (st_ff)
        ST_IDLE, ST_HOLD: begin
          if (start) begin
            st_ff   <= ST_SCAN;
            row_ff  <= '0;
            step_ff <= '0;
          end
        end
        ST_SCAN: begin
          if (step_ff == SCW'(ROW_CYC - 1)) begin
            step_ff <= '0;
            row_ff  <= row_ff + 1'b1;
            if (row_ff == `HKBS_LAST_ROW) st_ff <= ST_MAPF;
          end else begin
            step_ff <= step_ff + 1'b1;
          end
        end
        ST_MAPF, ST_MAPK: begin
          if (idx_ff == `HKBS_NPOS) begin
            idx_ff <= '0;
            if (st_ff == ST_MAPF) st_ff <= ST_MAPK;
            else st_ff <= (|mat_ff) ? ST_HOLD : ST_IDLE;
          end else begin
            idx_ff <= idx_ff + 1'b1;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst || start) per_ff <= '0;
    else if (!per_done) per_ff <= per_ff + 1'b1;
  end

  // columns sampled at the end of each row step, after synchroniser lag
  always_ff @(posedge clk) begin
    if (core_rst || go_sleep) begin
      mat_ff     <= '0;
      row_out_ff <= '0;
      osc_ff     <= 1'b0;
    end else begin
      if (st_ff == ST_SCAN && step_ff == SCW'(ROW_CYC - 1)) begin
        mat_ff[{row_ff, 3'h0} +: 8] <= ~col_ff;
      end
      row_out_ff <= (st_ff == ST_SCAN) ? ~(`HKBS_ROW0 << row_ff) : 16'h0000;
      osc_ff     <= st_ff != ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      fn_ff <= 1'b0;
    end else if (st_ff == ST_MAPF && idx_ff == 8'h00) begin
      fn_ff <= 1'b0;
    end else if (st_ff == ST_MAPF && proc && pressed
                 && map_if.pri == FN_CODE && FN_CODE != 8'h00) begin
      fn_ff <= 1'b1;
    end
  end

  // keys beyond six are dropped rather than flagged
  always_ff @(posedge clk) begin
    if (core_rst || (st_ff == ST_MAPK && idx_ff == 8'h00)) begin
      mod_acc_ff  <= '0;
      spec_acc_ff <= '0;
      keys_acc_ff <= '0;
      nk_ff       <= '0;
    end else if (st_ff == ST_MAPK && proc && pressed) begin
      unique case (key_class(code))
        CL_IGN: ;
        CL_MOD: mod_acc_ff[code[2:0]] <= 1'b1;
        CL_SPEC: spec_acc_ff[code[2:0]] <= 1'b1;
        CL_KEY: begin
          if (nk_ff < `HKBS_NKEYS) begin
            keys_acc_ff[{nk_ff, 3'h0} +: 8] <= code;
            nk_ff <= nk_ff + 1'b1;
          end
        end
      endcase
    end
  end

  always_comb begin
    nxt_rpt = '0;
    if (|spec_acc_ff) begin
      nxt_kind        = K_SPEC;
      nxt_rpt[7:0]    = `HKBS_SPEC_LEN;
      nxt_rpt[23:16]  = SPEC_ID;
      nxt_rpt[31:24]  = spec_acc_ff;
    end else begin
      nxt_kind        = K_DEF;
      nxt_rpt[7:0]    = `HKBS_DEF_LEN;
      nxt_rpt[23:16]  = DEF_ID;
      nxt_rpt[31:24]  = mod_acc_ff;
      nxt_rpt[87:40]  = keys_acc_ff;
    end
  end

  // one cycle after the last map step, so the final position is accumulated
  always_ff @(posedge clk) begin
    if (core_rst || go_sleep) rpt_done_ff <= 1'b0;
    else rpt_done_ff <= st_ff == ST_MAPK && idx_ff == `HKBS_NPOS;
  end

  always_ff @(posedge clk) begin
    if (core_rst || go_sleep) begin
      rpt_ff  <= '0;
      kind_ff <= K_EMPTY;
    end else if (rpt_done) begin
      rpt_ff  <= nxt_rpt;
      kind_ff <= nxt_kind;
    end
  end

  // shadow holds still between toggles, so the link copies a stable word
  always_ff @(posedge clk) begin
    if (rst) begin
      sh_rpt_ff  <= '0;
      sh_kind_ff <= K_EMPTY;
      pub_tgl_ff <= 1'b0;
    end else if (sh_rpt_ff != rpt_ff || sh_kind_ff != kind_ff) begin
      sh_rpt_ff  <= rpt_ff;
      sh_kind_ff <= kind_ff;
      pub_tgl_ff <= ~pub_tgl_ff;
    end
  end

  // a new report in the clearing cycle keeps the interrupt up
  always_ff @(posedge clk) begin
    if (core_rst) begin
      int_ff   <= 1'b1;
      int_n_ff <= 1'b0;
    end else begin
      if (new_rpt) int_ff <= 1'b1;
      else if (clr_ev) int_ff <= 1'b0;
      int_n_ff <= ~int_ff;
    end
  end

  assign row_drive_outputs = row_out_ff;
  assign indicator_outputs = led_out_ff;
  assign int_n             = int_n_ff;
  assign osc_en            = osc_ff;

  logic       lk_rst_s1_ff, lk_rst_ff, lk_bz_s1_ff, lk_bz_ff;
  logic       lk_pub_s1_ff, lk_pub_s2_ff, lk_pub_d_ff;
  logic [87:0] lk_rpt_ff;
  hkbs_kind_t lk_kind_ff;
  logic [3:0] lk_last;
  logic [7:0] lk_rd_ff;

  always_ff @(posedge link_clk) begin
    lk_rst_s1_ff <= rst;
    lk_rst_ff    <= lk_rst_s1_ff;
    lk_bz_s1_ff  <= srst_ff;
    lk_bz_ff     <= lk_bz_s1_ff;
  end

  always_comb begin
    unique case (lk_kind_ff)
      K_DEF:   lk_last = `HKBS_LAST_DEF;
      K_SPEC:  lk_last = `HKBS_LAST_SPEC;
      default: lk_last = `HKBS_LAST_EMPTY;
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (lk_rst_ff) begin
      {lk_pub_s1_ff, lk_pub_s2_ff, lk_pub_d_ff} <= 3'h0;
      lk_rpt_ff  <= '0;
      lk_kind_ff <= K_EMPTY;
    end else begin
      {lk_pub_s1_ff, lk_pub_s2_ff, lk_pub_d_ff} <= {pub_tgl_ff, lk_pub_s1_ff, lk_pub_s2_ff};
      if (lk_pub_s2_ff ^ lk_pub_d_ff) begin
        lk_rpt_ff  <= sh_rpt_ff;
        lk_kind_ff <= sh_kind_ff;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (lk_rst_ff) begin
      lk_cmd_tgl_ff <= 1'b0;
      lk_clr_tgl_ff <= 1'b0;
      lk_op_ff      <= '0;
      lk_len_ff     <= '0;
      lk_arg_ff     <= '0;
      lk_rd_ff      <= '0;
    end else begin
      if (lk_cmd_stb && !lk_bz_ff) begin
        lk_cmd_tgl_ff <= ~lk_cmd_tgl_ff;
        lk_op_ff      <= lk_cmd_op;
        lk_len_ff     <= lk_cmd_len;
        lk_arg_ff     <= lk_cmd_arg;
      end
      if (lk_ack_stb && !lk_bz_ff && lk_ack_input && lk_ack_idx == lk_last) begin
        lk_clr_tgl_ff <= ~lk_clr_tgl_ff;
      end
      lk_rd_ff <= (lk_rd_idx < `HKBS_NBYTES) ? lk_rpt_ff[{lk_rd_idx, 3'h0} +: 8] : 8'h00;
    end
  end

  assign lk_rd_data = lk_rd_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (core_rst);

  a_sleep_leds_off: assert property (sleeping_ff |=> led_out_ff == 4'h0)
    else $error("indicator lit while asleep");
  a_sleep_clears: assert property (go_sleep |=> rpt_ff == '0 && kind_ff == K_EMPTY)
    else $error("report not cleared on sleep");
  a_lock_no_scan: assert property (lock_ff && st_ff == ST_IDLE |=> st_ff == ST_IDLE)
    else $error("scan started while locked");
  a_wake_leds: assert property ($fell(sleeping_ff) |=> led_out_ff == $past(led_state_ff))
    else $error("indicators not restored on wake");
  a_zero_ignored: assert property (st_ff == ST_MAPK && proc && code == 8'h00
                                   |=> $stable(nk_ff) && $stable(mod_acc_ff))
    else $error("zero code counted");
  a_idle_rows_low: assert property (st_ff == ST_IDLE [*2] |-> row_out_ff == 16'h0000)
    else $error("row driven high in idle");
  a_one_row_low: assert property (st_ff == ST_SCAN && $past(st_ff) == ST_SCAN
                                  |-> $onehot(~row_out_ff) && osc_ff)
    else $error("scan row pattern wrong");
  a_int_on_report: assert property (new_rpt |=> ##1 !int_n_ff)
    else $error("interrupt not raised for new report");
  a_clear_cause: assert property ($fell(int_ff) |-> $past(clr_ev) && !$past(new_rpt))
    else $error("interrupt cleared without input read");
  a_reset_int: assert property ($fell(srst_ff) |=> ##1 !int_n_ff && kind_ff == K_EMPTY)
    else $error("soft reset did not announce");

  c_report: cover property (new_rpt ##[1:8] !int_n_ff);
  c_sleep_wake: cover property (go_sleep ##[1:1000] go_wake);
  c_soft_reset: cover property (go_reset ##1 srst_ff);
  c_alt_map: cover property (rpt_done && fn_ff);
endmodule

//--- verification/hkbs_host_model.sv
// host side of the link: commands, report byte reads and ack pulses
// assumes a free-running link_clk; the bench calls its tasks by hierarchy
`timescale 1ns/1ns
module hkbs_host_model (
  input  wire logic        link_clk,     // link clock
  input  wire logic [7:0]  lk_rd_data,   // report byte
  output logic             lk_cmd_stb,   // command pulse
  output logic      [3:0]  lk_cmd_op,    // opcode
  output logic      [15:0] lk_cmd_len,   // length field
  output logic      [7:0]  lk_cmd_arg,   // payload byte
  output logic      [3:0]  lk_rd_idx,    // byte index
  output logic             lk_ack_stb,   // ack bit pulse
  output logic      [3:0]  lk_ack_idx,   // acked byte index
  output logic             lk_ack_input  // input register read
);
  logic        hold = 1'b0;
  logic [27:0] q    = 28'h0000000;
  logic [27:0] w    = 28'h0000000;
  initial begin
    lk_cmd_stb = 1'b0;
    lk_rd_idx = 4'h0;
    lk_ack_stb = 1'b0;
    lk_ack_idx = 4'h0;
    lk_ack_input = 1'b0;
  end
  // released fields wander so a late sample of them cannot pass unseen
  always @(posedge link_clk) w <= w + 28'h9E3779B;
  assign {lk_cmd_op, lk_cmd_len, lk_cmd_arg} = hold ? q : ~q ^ w;
  // fields held five link cycles, the spacing the core needs
  task automatic cmd(input logic [3:0] op, input logic [15:0] len, input logic [7:0] arg);
    @(posedge link_clk);
    q <= {op, len, arg};
    hold <= 1'b1;
    lk_cmd_stb <= 1'b1;
    @(posedge link_clk);
    lk_cmd_stb <= 1'b0;
    repeat (4) @(posedge link_clk);
    hold <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] idx, output logic [7:0] b);
    @(posedge link_clk);
    lk_rd_idx <= idx;
    repeat (2) @(posedge link_clk);
    b = lk_rd_data;
  endtask
  // serviced within a few link cycles of being asked
  task automatic ack(input logic [3:0] idx, input logic inp);
    @(posedge link_clk);
    lk_ack_stb <= 1'b1;
    lk_ack_idx <= idx;
    lk_ack_input <= inp;
    @(posedge link_clk);
    lk_ack_stb <= 1'b0;
  endtask
endmodule

//--- verification/tb.sv
// bench for the keyboard scan core: key matrix, host model, scoreboard
// assumes shortened row, period and soft reset counts
`timescale 1ns/1ns
`include "hkbs_params.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb;
  logic         clk = 1'b0, link_clk = 1'b0, rst = 1'b1, map_wr_en = 1'b0;
  logic [7:0]   map_wr_addr = 8'h00, map_wr_data = 8'h00;
  logic [7:0]   column_sense_inputs, lk_cmd_arg, lk_rd_data, b;
  logic [15:0]  row_drive_outputs, lk_cmd_len;
  logic [3:0]   indicator_outputs, lk_cmd_op, lk_rd_idx, lk_ack_idx;
  logic         int_n, osc_en, lk_cmd_stb, lk_ack_stb, lk_ack_input;
  logic [127:0] keys = '0, k;
  logic [127:0] corner [5] = '{128'h21, 128'h42, {1'b1, 123'h0, 4'h4}, 128'h8, 128'h7F0};
  logic [31:0]  s = 32'h0000914F;
  int           mismatches = 0, compares = 0, cyc = 0, q;
  hkbs_core #(.ROW_CYC(8), .PER_CYC(400), .RST_CYC(20)) u_hkbs_core (.*);
  hkbs_host_model u_hkbs_host_model (.*);
  initial forever #4 clk = ~clk;
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end
  // matrix: a pressed key pulls its column low while its row is driven
  always_comb begin
    column_sense_inputs = 8'hFF;
    for (int r = 0; r < 16; r++)
      if (row_drive_outputs[r] === 1'b0) column_sense_inputs &= ~keys[r*8 +: 8];
  end
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [7:0] pc(input logic [6:0] p);
    case (p)
      7'h00: return 8'h00;
      7'h01: return 8'hF0;
      7'h02: return 8'hE1;
      7'h03: return 8'hC2;
      default: return 8'h10 + {1'b0, p};
    endcase
  endfunction
  function automatic logic [7:0] ac(input logic [6:0] p);
    return p < 7'h04 ? pc(p) : pc(p) + 8'h01;
  endfunction
  function automatic logic [87:0] rep(input logic [127:0] kk);
    logic [47:0] ks;
    logic [7:0]  c, mods, sp;
    int          n;
    ks = '0;
    mods = '0;
    sp = '0;
    n = 0;
    for (int p = 0; p < 128; p++) begin
      c = kk[1] ? ac(7'(p)) : pc(7'(p));
      if (!kk[p] || c == 8'h00 || c == 8'hF0) continue;
      if (c[7:3] == 5'h18) sp[c[2:0]] = 1'b1;
      else if (c[7:3] == `HKBS_MOD_PFX) mods[c[2:0]] = 1'b1;
      else if (n < 6) begin
        ks[n*8 +: 8] = c;
        n++;
      end
    end
    if (sp != 8'h00) return {56'h0, sp, 8'h02, 8'h00, `HKBS_SPEC_LEN};
    return {ks, 8'h00, mods, 8'h01, 8'h00, `HKBS_DEF_LEN};
  endfunction
  task automatic final_report();
    if (mismatches == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_int();
    for (int i = 0; i < 3000 && int_n !== 1'b0; i++) @(posedge clk);
    `CHK("int_n", 1'b0, int_n)
    // a scan that straddled the key change is superseded one period later
    tick(450);
  endtask
  task automatic clear(input logic [3:0] i);
    u_hkbs_host_model.ack(i, 1'b1);
    tick(10);
    `CHK("int_n", 1'b1, int_n)
  endtask
  task automatic chk_rep(input logic [87:0] e, input int f);
    for (int i = f; i < 11; i++) begin
      u_hkbs_host_model.rd(4'(i), b);
      `CHK("report", e[i*8 +: 8], b)
    end
  endtask
  task automatic press(input logic [127:0] kk);
    @(posedge clk) keys <= kk;
    wait_int();
    chk_rep(rep(kk), 0);
    clear(rep(kk) [7:0] == `HKBS_SPEC_LEN ? 4'h3 : 4'hA);
  endtask
  // empty-kind or default-kind release report: either ack clears it
  task automatic rel_all();
    @(posedge clk) keys <= '0;
    wait_int();
    chk_rep('0, 3);
    u_hkbs_host_model.ack(4'h1, 1'b1);
    clear(4'hA);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!rst && row_drive_outputs !== 16'h0000)
      `CHK("scan_row", 1'b1, $countones(row_drive_outputs) == 15 && osc_en === 1'b1)
    if (cyc == 90000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    repeat (3) @(posedge link_clk);
    @(posedge clk) rst <= 1'b0;
    for (int a = 0; a < 256; a++) begin
      @(posedge clk);
      map_wr_en <= 1'b1;
      map_wr_addr <= 8'(a);
      map_wr_data <= a[7] ? ac(7'(a)) : pc(7'(a));
    end
    @(posedge clk) map_wr_en <= 1'b0;
    `CHK("int_n", 1'b0, int_n)
    `CHK("ind", 4'h0, indicator_outputs)
    `CHK("rows", 16'h0000, row_drive_outputs)
    chk_rep('0, 0);
    u_hkbs_host_model.ack(4'h1, 1'b0);
    tick(10);
    `CHK("int_n", 1'b0, int_n)
    clear(4'h1);
    for (int t = 0; t < 4; t++) begin
      b = 8'(rnd());
      u_hkbs_host_model.cmd(`HKBS_OP_SET, `HKBS_OUT_LEN, b);
      tick(10);
      `CHK("ind", b[3:0], indicator_outputs)
      u_hkbs_host_model.cmd(`HKBS_OP_SET, 16'h0004, ~b);
      u_hkbs_host_model.cmd(`HKBS_OP_GET, `HKBS_OUT_LEN, ~b);
      tick(10);
      `CHK("ind", b[3:0], indicator_outputs)
    end
    for (int t = 0; t < 11; t++) begin
      k = t < 5 ? corner[t] : '0;
      for (int j = 0; t >= 5 && j < t % 3 + 1; j++) k[7'(rnd() % 124 + 4)] = 1'b1;
      press(k);
      if ($countones(k[127:4]) > 1) begin
        for (int p = 127; p >= 4; p--) if (k[p]) q = p;
        k[q] = 1'b0;
        press(k);
      end
      rel_all();
    end
    @(posedge clk) keys[20] <= 1'b1;
    wait_int();
    @(posedge clk) keys[40] <= 1'b1;
    tick(1000);
    chk_rep(rep(keys), 0);
    clear(4'hA);
    rel_all();
    k = '0;
    k[50] = 1'b1;
    press(k);
    b = 8'(rnd());
    u_hkbs_host_model.cmd(`HKBS_OP_SET, `HKBS_OUT_LEN, b);
    u_hkbs_host_model.cmd(`HKBS_OP_PWR, 16'h0000, `HKBS_PWR_SLEEP);
    tick(10);
    `CHK("ind", 4'h0, indicator_outputs)
    `CHK("rows", 16'h0000, row_drive_outputs)
    chk_rep('0, 0);
    u_hkbs_host_model.cmd(`HKBS_OP_SET, `HKBS_OUT_LEN, ~b);
    tick(1000);
    `CHK("ind", 4'h0, indicator_outputs)
    `CHK("int_n", 1'b1, int_n)
    u_hkbs_host_model.cmd(`HKBS_OP_PWR, 16'h0000, 8'h00);
    tick(10);
    `CHK("ind", 4'(~b), indicator_outputs)
    press(k);
    tick(1000);
    `CHK("int_n", 1'b1, int_n)
    u_hkbs_host_model.cmd(`HKBS_OP_PWR, 16'h0000, `HKBS_PWR_SLEEP);
    @(posedge clk) keys <= '0;
    tick(50);
    k = '0;
    k[60] = 1'b1;
    press(k);
    rel_all();
    u_hkbs_host_model.cmd(`HKBS_OP_PWR, 16'h0000, 8'h00);
    u_hkbs_host_model.cmd(`HKBS_OP_SET, `HKBS_OUT_LEN, 8'h0F);
    u_hkbs_host_model.cmd(`HKBS_OP_RESET, 16'h0000, 8'h00);
    tick(60);
    `CHK("int_n", 1'b0, int_n)
    `CHK("ind", 4'h0, indicator_outputs)
    chk_rep('0, 0);
    final_report();
  end
endmodule
